// file: core/asc_top.sv
// converter channel select, scan mask, compare hit and current source enable registers on APB
// assumes a converter core that answers conv_start with one conv_done pulse and a result
// Operation
// - sample A negative select in bits 7..5
// - sample A positive select in bits 4..0
// - negative code 0 ground, 1..7 inputs 0..6
// - compare mode: less, greater, inside, outside
// - mode 11: any buffer write sets hit
// - other modes: only a match sets hit
// - 24 hit bits, high word bits 15..8 zero
// - scan includes channel only when mask set
// - scan high word: 30..26 at 14..10, 23..16 low
// - current source enabled on channel during conversion only when its enable bit set
// - unimplemented channel bits read as zero
// - sampling completes before conversion starts
`timescale 1ns/10ps
`include "asc_cfg.svh"
module asc_top #(
   parameter int PIN_COUNT = 44
) (
   // clock and reset
   input logic pclk,
   input logic presetn,
   // apb slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter core
   input logic conv_done,
   input logic [11:0] conv_result,
   output logic [4:0] pos_select,
   output logic [2:0] neg_select,
   output logic neg_ground,
   output logic [6:0] neg_input,
   output logic sampling,
   output logic conv_start,
   output logic [4:0] conv_chan,
   output logic current_source_en,
   // interrupt
   output logic irq
);
   import asc_pkg::*;

   localparam logic [23:0] IMPL = (PIN_COUNT <= 20) ? `ASC_MASK_20PIN :
                                  (PIN_COUNT <= 28) ? `ASC_MASK_28PIN : `ASC_MASK_44PIN;

   function automatic asc_reg_t decode(input logic [7:0] a);
      if (a == `ASC_OFS_MUX) begin
         decode = ASC_R_MUX;
      end else if (a == `ASC_OFS_HITL) begin
         decode = ASC_R_HITL;
      end else if (a == `ASC_OFS_HITH) begin
         decode = ASC_R_HITH;
      end else if (a == `ASC_OFS_SCANL) begin
         decode = ASC_R_SCANL;
      end else if (a == `ASC_OFS_SCANH) begin
         decode = ASC_R_SCANH;
      end else if (a == `ASC_OFS_CSL) begin
         decode = ASC_R_CSL;
      end else if (a == `ASC_OFS_CSH) begin
         decode = ASC_R_CSH;
      end else if (a == `ASC_OFS_CTRL) begin
         decode = ASC_R_CTRL;
      end else if (a == `ASC_OFS_THRLO) begin
         decode = ASC_R_THRLO;
      end else if (a == `ASC_OFS_THRHI) begin
         decode = ASC_R_THRHI;
      end else if (a == `ASC_OFS_STAT) begin
         decode = ASC_R_STAT;
      end else if (a == `ASC_OFS_IMASK) begin
         decode = ASC_R_IMASK;
      end else begin
         decode = ASC_R_NONE;
      end
   endfunction

   asc_seq_if sq ();

   logic [15:0] input_mux_select_r;
   logic [23:0] compare_hit_flags_r;
   logic [23:0] scan_include_mask_r;
   logic [4:0] scan_extra_r;
   logic [23:0] current_source_channel_enable_r;
   asc_cmode_t compare_mode_select_r;
   logic scan_en_r;
   logic [7:0] sample_cycles_r;
   logic [11:0] thr_lo_r;
   logic [11:0] thr_hi_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic [31:0] prdata_r;
   asc_reg_t sel_reg;
   logic wr;
   logic [15:0] wd;
   logic match;
   logic [23:0] hit_set;
   logic [23:0] chan_bit;
   logic [1:0] ev;

   assign sel_reg = decode(paddr);
   assign pready = 1'b1;
   assign pslverr = psel && penable && (sel_reg == ASC_R_NONE);
   assign wr = psel && penable && pwrite && pready;
   assign wd = pwdata[15:0];

   // read data is captured in the setup cycle so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= 32'h00000000;
         case (decode(paddr))
            ASC_R_MUX: prdata_r[15:0] <= input_mux_select_r;
            ASC_R_HITL: prdata_r[15:0] <= compare_hit_flags_r[15:0] & IMPL[15:0];
            ASC_R_HITH: prdata_r[7:0] <= compare_hit_flags_r[23:16] & IMPL[23:16];
            ASC_R_SCANL: prdata_r[15:0] <= scan_include_mask_r[15:0] & IMPL[15:0];
            ASC_R_SCANH: begin
               prdata_r[`ASC_SCANH_HI_MSB:`ASC_SCANH_HI_LSB] <= scan_extra_r;
               prdata_r[7:0] <= scan_include_mask_r[23:16] & IMPL[23:16];
            end
            ASC_R_CSL: prdata_r[15:0] <= current_source_channel_enable_r[15:0] & IMPL[15:0];
            ASC_R_CSH: prdata_r[7:0] <= current_source_channel_enable_r[23:16] & IMPL[23:16];
            ASC_R_CTRL: begin
               prdata_r[`ASC_CM_MSB:`ASC_CM_LSB] <= compare_mode_select_r;
               prdata_r[`ASC_SCANEN_BIT] <= scan_en_r;
               prdata_r[`ASC_SMP_MSB:`ASC_SMP_LSB] <= sample_cycles_r;
            end
            ASC_R_THRLO: prdata_r[11:0] <= thr_lo_r;
            ASC_R_THRHI: prdata_r[11:0] <= thr_hi_r;
            ASC_R_STAT: prdata_r[1:0] <= irq_stat_r;
            ASC_R_IMASK: prdata_r[1:0] <= irq_mask_r;
            default: prdata_r <= 32'h00000000;
         endcase
      end
   end
   assign prdata = prdata_r;

   // input select register, both sample A fields and the sample B fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_mux_select_r <= `ASC_RST_16;
      end else if (wr && sel_reg == ASC_R_MUX) begin
         input_mux_select_r <= wd;
      end
   end

   // control and compare window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_mode_select_r <= ASC_CM_LESS;
         scan_en_r <= 1'b0;
         sample_cycles_r <= `ASC_RST_SMP;
         thr_lo_r <= 12'h000;
         thr_hi_r <= `ASC_RST_THRHI;
      end else if (wr) begin
         if (sel_reg == ASC_R_CTRL) begin
            compare_mode_select_r <= asc_cmode_t'(wd[`ASC_CM_MSB:`ASC_CM_LSB]);
            scan_en_r <= wd[`ASC_SCANEN_BIT];
            sample_cycles_r <= wd[`ASC_SMP_MSB:`ASC_SMP_LSB];
         end else if (sel_reg == ASC_R_THRLO) begin
            thr_lo_r <= wd[11:0];
         end else if (sel_reg == ASC_R_THRHI) begin
            thr_hi_r <= wd[11:0];
         end
      end
   end

   // scan mask; unimplemented channels never hold a one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_include_mask_r <= `ASC_RST_24;
         scan_extra_r <= 5'h00;
      end else if (wr && sel_reg == ASC_R_SCANL) begin
         scan_include_mask_r[15:0] <= wd & IMPL[15:0];
      end else if (wr && sel_reg == ASC_R_SCANH) begin
         scan_include_mask_r[23:16] <= wd[7:0] & IMPL[23:16];
         scan_extra_r <= wd[`ASC_SCANH_HI_MSB:`ASC_SCANH_HI_LSB];
      end
   end

   // current source channel enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_source_channel_enable_r <= `ASC_RST_24;
      end else if (wr && sel_reg == ASC_R_CSL) begin
         current_source_channel_enable_r[15:0] <= wd & IMPL[15:0];
      end else if (wr && sel_reg == ASC_R_CSH) begin
         current_source_channel_enable_r[23:16] <= wd[7:0] & IMPL[23:16];
      end
   end

   // compare against the window pair: one pair shared by every channel
   always_comb begin
      case (compare_mode_select_r)
         ASC_CM_LESS: match = conv_result < thr_lo_r;
         ASC_CM_GREATER: match = conv_result > thr_hi_r;
         ASC_CM_INSIDE: match = (conv_result >= thr_lo_r) && (conv_result <= thr_hi_r);
         ASC_CM_OUTSIDE: match = (conv_result < thr_lo_r) || (conv_result > thr_hi_r);
         default: match = 1'b0;
      endcase
   end

   generate
      for (genvar i = 0; i < 24; i++) begin : g_chan
         assign chan_bit[i] = (sq.chan == 5'(i)) && IMPL[i];
      end
   endgenerate

   // a result write counts as a hit only in outside-window mode
   assign hit_set = (conv_done && sq.converting &&
                     ((compare_mode_select_r == ASC_CM_OUTSIDE) || match)) ? chan_bit :
                    `ASC_RST_24;

   // hit flags: a hardware set wins over a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_hit_flags_r <= `ASC_RST_24;
      end else if (wr && sel_reg == ASC_R_HITL) begin
         compare_hit_flags_r <= {compare_hit_flags_r[23:16], wd & IMPL[15:0]} | hit_set;
      end else if (wr && sel_reg == ASC_R_HITH) begin
         compare_hit_flags_r <= {wd[7:0] & IMPL[23:16], compare_hit_flags_r[15:0]} | hit_set;
      end else begin
         compare_hit_flags_r <= compare_hit_flags_r | hit_set;
      end
   end

   // interrupt status: write one to clear, new events win
   assign ev[`ASC_STAT_DONE] = sq.seq_done;
   assign ev[`ASC_STAT_MATCH] = |(hit_set & {24{match}});
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= 2'b00;
      end else if (wr && sel_reg == ASC_R_STAT) begin
         irq_stat_r <= (irq_stat_r & ~wd[1:0]) | ev;
      end else begin
         irq_stat_r <= irq_stat_r | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_r <= 2'b00;
      end else if (wr && sel_reg == ASC_R_IMASK) begin
         irq_mask_r <= wd[1:0];
      end
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   // sequencer hookup; the extra internal channels sit at 30..26
   assign sq.scan_en = scan_en_r;
   assign sq.mask = {scan_extra_r, 2'b00, scan_include_mask_r & IMPL};
   assign sq.sample_cycles = sample_cycles_r;
   assign sq.conv_done = conv_done;

   asc_scan_seq u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .sq(sq)
   );

   // outside a scan the sample A positive field drives the multiplexer
   assign pos_select = scan_en_r ? sq.chan :
                       input_mux_select_r[`ASC_POSA_MSB:`ASC_POSA_LSB];
   assign neg_select = input_mux_select_r[`ASC_NEGA_MSB:`ASC_NEGA_LSB];
   assign neg_ground = (neg_select == 3'h0);
   generate
      for (genvar n = 0; n < 7; n++) begin : g_neg
         assign neg_input[n] = (neg_select == 3'(n + 1));
      end
   endgenerate

   assign sampling = sq.sampling;
   assign conv_start = sq.conv_start;
   assign conv_chan = sq.chan;
   // current source only while converting a channel whose enable bit is set
   assign current_source_en = sq.converting &&
                               |(chan_bit & current_source_channel_enable_r);
endmodule

// file: core/asc_cfg.svh
// register map, field positions, reset values and timing counts of the scan select block
// assumes a 250 MHz pclk and a 32-bit APB with byte addresses
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

`define ASC_OFS_MUX 8'h00
`define ASC_OFS_HITL 8'h04
`define ASC_OFS_HITH 8'h08
`define ASC_OFS_SCANL 8'h0C
`define ASC_OFS_SCANH 8'h10
`define ASC_OFS_CSL 8'h14
`define ASC_OFS_CSH 8'h18
`define ASC_OFS_CTRL 8'h1C
`define ASC_OFS_THRLO 8'h20
`define ASC_OFS_THRHI 8'h24
`define ASC_OFS_STAT 8'h28
`define ASC_OFS_IMASK 8'h2C

`define ASC_NEGA_MSB 7
`define ASC_NEGA_LSB 5
`define ASC_POSA_MSB 4
`define ASC_POSA_LSB 0
`define ASC_CM_MSB 1
`define ASC_CM_LSB 0
`define ASC_SCANEN_BIT 2
`define ASC_SMP_MSB 15
`define ASC_SMP_LSB 8
`define ASC_SCANH_HI_MSB 14
`define ASC_SCANH_HI_LSB 10
`define ASC_STAT_DONE 0
`define ASC_STAT_MATCH 1

`define ASC_RST_16 16'h0000
`define ASC_RST_24 24'h000000
`define ASC_RST_SMP 8'h01
`define ASC_RST_THRHI 12'hFFF

`define ASC_MASK_20PIN 24'hF9FE1F
`define ASC_MASK_28PIN 24'hFFFE3F
`define ASC_MASK_44PIN 24'hFFFFFF

`define ASC_CLK_MHZ 250
`define ASC_MIN_SAMPLE_NS 4

`endif

// file: core/asc_pkg.sv
// types shared by the scan select block and its sequencer
package asc_pkg;
   typedef enum logic [2:0] {
      ASC_IDLE = 3'b001,
      ASC_SAMPLE = 3'b010,
      ASC_CONVERT = 3'b100
   } asc_state_t;
   typedef enum logic [1:0] {
      ASC_CM_LESS = 2'b00,
      ASC_CM_GREATER = 2'b01,
      ASC_CM_INSIDE = 2'b10,
      ASC_CM_OUTSIDE = 2'b11
   } asc_cmode_t;
   typedef enum logic [3:0] {
      ASC_R_MUX, ASC_R_HITL, ASC_R_HITH, ASC_R_SCANL, ASC_R_SCANH, ASC_R_CSL,
      ASC_R_CSH, ASC_R_CTRL, ASC_R_THRLO, ASC_R_THRHI, ASC_R_STAT, ASC_R_IMASK,
      ASC_R_NONE
   } asc_reg_t;
endpackage

// file: core/asc_seq_if.sv
// bundle between the register block and the scan sequencer
// assumes both ends run on the same pclk
`timescale 1ns/10ps
interface asc_seq_if;
   logic scan_en;
   logic [30:0] mask;
   logic [7:0] sample_cycles;
   logic conv_done;
   logic [4:0] chan;
   logic sampling;
   logic converting;
   logic conv_start;
   logic seq_done;
   modport ctrl (output scan_en, mask, sample_cycles, conv_done,
                 input chan, sampling, converting, conv_start, seq_done);
   modport seq (input scan_en, mask, sample_cycles, conv_done,
                output chan, sampling, converting, conv_start, seq_done);
endinterface

// file: core/asc_scan_seq.sv
// scan sequencer: walks the enabled channels in ascending order, one sample and conversion each
// assumes conv_done is a one-cycle pulse from the converter core after conv_start
`timescale 1ns/10ps
`include "asc_cfg.svh"
module asc_scan_seq (
   // clock and reset
   input logic pclk,
   input logic presetn,
   // control bundle
   asc_seq_if.seq sq
);
   import asc_pkg::*;

   localparam logic [7:0] MIN_SMP =
      8'((`ASC_MIN_SAMPLE_NS * `ASC_CLK_MHZ + 999) / 1000);

   asc_state_t state_r;
   logic [4:0] chan_r;
   logic [7:0] cnt_r;
   logic start_r;
   logic done_r;
   logic [4:0] up_idx;
   logic up_found;
   logic [4:0] low_idx;
   logic [7:0] smp_load;

   // lowest enabled channel above the current one, and lowest overall for the wrap
   always_comb begin
      up_found = 1'b0;
      up_idx = 5'h00;
      low_idx = 5'h00;
      for (int i = 30; i >= 0; i--) begin
         if (sq.mask[i]) begin
            low_idx = 5'(i);
            if (5'(i) > chan_r) begin
               up_found = 1'b1;
               up_idx = 5'(i);
            end
         end
      end
   end

   // a too short sample field is stretched to the minimum sample time
   assign smp_load = (sq.sample_cycles < MIN_SMP) ? MIN_SMP : sq.sample_cycles;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ASC_IDLE;
         chan_r <= 5'h00;
         cnt_r <= 8'h00;
         start_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         start_r <= 1'b0;
         done_r <= 1'b0;
         case (state_r)
            ASC_IDLE: begin
               if (sq.scan_en && |sq.mask) begin
                  chan_r <= low_idx;
                  cnt_r <= smp_load;
                  state_r <= ASC_SAMPLE;
               end
            end
            ASC_SAMPLE: begin
               // conversion only once the full sample time has passed
               if (cnt_r <= 8'h01) begin
                  start_r <= 1'b1;
                  state_r <= ASC_CONVERT;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            ASC_CONVERT: begin
               if (sq.conv_done) begin
                  done_r <= !up_found;
                  if (!sq.scan_en || !(|sq.mask)) begin
                     state_r <= ASC_IDLE;
                  end else begin
                     chan_r <= up_found ? up_idx : low_idx;
                     cnt_r <= smp_load;
                     state_r <= ASC_SAMPLE;
                  end
               end
            end
            default: begin
               state_r <= ASC_IDLE;
            end
         endcase
      end
   end

   assign sq.chan = chan_r;
   assign sq.sampling = (state_r == ASC_SAMPLE);
   assign sq.converting = (state_r == ASC_CONVERT);
   assign sq.conv_start = start_r;
   assign sq.seq_done = done_r;
endmodule

// file: sim/asc_top_props.sv
// checker for the scan select block, watching only the top ports
// assumes it is bound into asc_top and the register map of asc_cfg.svh
`timescale 1ns/10ps
`include "asc_cfg.svh"
module asc_top_chk #(
   parameter int PIN_COUNT = 44
) (
   // clock and reset
   input logic pclk,
   input logic presetn,
   // apb
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] prdata,
   // converter side
   input logic conv_done,
   input logic [2:0] neg_select,
   input logic neg_ground,
   input logic [6:0] neg_input,
   input logic sampling,
   input logic conv_start,
   input logic [4:0] conv_chan,
   input logic current_source_en
);
   localparam logic [23:0] IMPL = (PIN_COUNT == 20) ? `ASC_MASK_20PIN :
      (PIN_COUNT == 28) ? `ASC_MASK_28PIN : `ASC_MASK_44PIN;
   logic busy_r;
   logic rd_acc;
   assign rd_acc = psel && penable && !pwrite;
   // open from the start pulse up to the cycle of the done answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'b0;
      end else if (conv_start) begin
         busy_r <= 1'b1;
      end else if (conv_done) begin
         busy_r <= 1'b0;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_neg_ground: assert property (neg_ground == (neg_select == 3'h0))
      else $error("ground flag disagrees with negative code");
   chk_neg_onehot: assert property (neg_select != 3'h0 |->
      neg_input == (7'h01 << (neg_select - 3'h1)))
      else $error("negative input decode wrong");
   chk_sample_first: assert property ($fell(sampling) |-> conv_start)
      else $error("sampling ended without a start");
   chk_start_pulse: assert property (conv_start |-> !sampling ##1 !conv_start)
      else $error("start pulse overlaps sampling or lasts");
   chk_chan_steady: assert property (sampling && $past(sampling) |-> $stable(conv_chan))
      else $error("channel moved while sampling");
   chk_cs_in_conv: assert property (current_source_en |-> conv_start || busy_r)
      else $error("current source on outside conversion");
   chk_hith_upper: assert property (rd_acc && paddr == `ASC_OFS_HITH |->
      prdata[15:8] == 8'h00)
      else $error("hit high word upper byte not zero");
   chk_scanh_gaps: assert property (rd_acc && paddr == `ASC_OFS_SCANH |->
      prdata[15] == 1'b0 && prdata[9:8] == 2'b00)
      else $error("scan high word gap bits not zero");
   chk_unimpl_zero: assert property (rd_acc && (paddr == `ASC_OFS_HITL ||
      paddr == `ASC_OFS_SCANL || paddr == `ASC_OFS_CSL) |->
      (prdata[15:0] & ~IMPL[15:0]) == 16'h0000)
      else $error("unimplemented channel bit reads one");
endmodule

// file: sim/asc_conv_model.sv
// behavioural converter core: one done pulse per start pulse after a set latency
// assumes the bench sets a latency of at least 1 and the result value
`timescale 1ns/10ps
module asc_conv_model (
   // clock and reset
   input logic pclk,
   input logic presetn,
   // from the block
   input logic conv_start,
   // bench settings
   input logic [3:0] lat,
   input logic [11:0] res,
   // answer
   output logic conv_done,
   output logic [11:0] conv_result
);
   logic [3:0] cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         conv_done <= 1'b0;
         conv_result <= 12'h000;
      end else begin
         conv_done <= 1'b0;
         // result only valid with done; it toggles elsewhere so no stale value passes
         conv_result <= ~conv_result;
         if (conv_start) begin
            cnt_r <= lat;
         end else if (cnt_r == 4'h1) begin
            cnt_r <= 4'h0;
            conv_done <= 1'b1;
            conv_result <= res;
         end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule

// file: sim/asc_top_bench.sv
// self-checking bench for the scan select block with a converter model
// assumes asc_top built for 20 pins and the map of asc_cfg.svh
`timescale 1ns/10ps
`include "asc_cfg.svh"
module asc_top_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] lat = 4'h1;
   logic [11:0] res = 12'h000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, conv_done, sampling, conv_start, cs_en, irq, neg_ground, rerr;
   logic [11:0] conv_result;
   logic [4:0] pos_select, conv_chan;
   logic [2:0] neg_select;
   logic [6:0] neg_input;
   int err_count = 0;
   int checked = 0;
   always #2 pclk = ~pclk;
   asc_top #(.PIN_COUNT(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .conv_result(conv_result),
      .pos_select(pos_select), .neg_select(neg_select), .neg_ground(neg_ground),
      .neg_input(neg_input), .sampling(sampling), .conv_start(conv_start),
      .conv_chan(conv_chan), .current_source_en(cs_en), .irq(irq));
   asc_conv_model model_u (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
      .lat(lat), .res(res), .conv_done(conv_done), .conv_result(conv_result));
   task automatic end_of_test();
      $display("checked %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one transfer, entered just after an edge; leaves one idle edge behind
   task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         end_of_test();
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic run_scan(input logic [4:0] exp [$], input logic [4:0] cs_ch);
      int n;
      int got;
      n = 0;
      got = 0;
      while (got < exp.size() && n < 500) begin
         @(posedge pclk);
         #1;
         n++;
         if (conv_start === 1'b1) begin
            chk({27'h0, conv_chan}, {27'h0, exp[got]});
            chk({27'h0, pos_select}, {27'h0, exp[got]});
            chk({31'h0, cs_en}, 32'(conv_chan == cs_ch));
            got++;
         end
      end
      if (got < exp.size()) begin
         err_count++;
         end_of_test();
      end
      @(posedge pclk);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 12; i++) begin
         apb(1'b0, 8'(i * 4), 16'h0000);
         chk(rd, (i == 7) ? 32'h100 : (i == 9) ? 32'hFFF : 32'h0);
      end
      apb(1'b0, 8'h30, 16'h0000);
      chk({31'h0, rerr}, 32'h1);
      chk(rd, 32'h0);
      @(negedge pclk);
      chk({31'h0, neg_ground}, 32'h1);
      @(posedge pclk);
      $display("test reset done");
   endtask
   task automatic t_mux();
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, `ASC_OFS_MUX, 16'(k * 32 + k * 3));
         apb(1'b0, `ASC_OFS_MUX, 16'h0000);
         chk(rd, 32'(k * 32 + k * 3));
         @(negedge pclk);
         chk({27'h0, pos_select}, 32'(k * 3));
         chk({29'h0, neg_select}, 32'(k));
         chk({31'h0, neg_ground}, 32'(k == 0));
         chk({25'h0, neg_input}, (k == 0) ? 32'h0 : 32'h1 << (k - 1));
         @(posedge pclk);
      end
      apb(1'b1, `ASC_OFS_MUX, 16'h0000);
      $display("test mux done");
   endtask
   task automatic t_regs();
      logic [15:0] ex [6] = '{16'hFE1F, 16'h00F9, 16'hFE1F, 16'h7CF9, 16'hFE1F, 16'h00F9};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 8'(i * 4 + 4), 16'hFFFF);
         apb(1'b0, 8'(i * 4 + 4), 16'h0000);
         chk(rd, {16'h0, ex[i]});
         apb(1'b1, 8'(i * 4 + 4), 16'h0000);
      end
      $display("test registers done");
   endtask
   task automatic t_scan();
      apb(1'b1, `ASC_OFS_SCANL, 16'h0015);
      apb(1'b1, `ASC_OFS_SCANH, 16'h0001);
      apb(1'b1, `ASC_OFS_CSL, 16'h0004);
      lat <= 4'h6;
      // three sample cycles so the channel is seen holding across a sample phase
      apb(1'b1, `ASC_OFS_CTRL, 16'h0307);
      run_scan('{5'h00, 5'h02, 5'h04, 5'h10}, 5'h02);
      apb(1'b1, `ASC_OFS_CTRL, 16'h0103);
      // long enough for the slowest model answer to land
      repeat (40) @(posedge pclk);
      apb(1'b0, `ASC_OFS_HITL, 16'h0000);
      chk(rd, 32'h0015);
      apb(1'b0, `ASC_OFS_HITH, 16'h0000);
      chk(rd, 32'h0001);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `ASC_OFS_IMASK, 16'h0001);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `ASC_OFS_STAT, 16'h0003);
      chk({31'h0, irq}, 32'h0);
      $display("test scan done");
   endtask
   task automatic t_modes();
      // mode, expected hit, result
      logic [15:0] tb [7] = '{16'h1300, 16'h0600, 16'h3900, 16'h2600, 16'h5600, 16'h4900,
         16'h7600};
      apb(1'b1, `ASC_OFS_THRLO, 16'h0400);
      apb(1'b1, `ASC_OFS_THRHI, 16'h0800);
      apb(1'b1, `ASC_OFS_SCANL, 16'h0002);
      apb(1'b1, `ASC_OFS_SCANH, 16'h0000);
      lat <= 4'h1;
      for (int i = 0; i < 7; i++) begin
         res <= tb[i][11:0];
         apb(1'b1, `ASC_OFS_HITL, 16'h0000);
         apb(1'b1, `ASC_OFS_CTRL, 16'h0104 | 16'(tb[i][14:13]));
         run_scan('{5'h01}, 5'h1F);
         apb(1'b1, `ASC_OFS_CTRL, 16'h0100);
         repeat (20) @(posedge pclk);
         apb(1'b0, `ASC_OFS_HITL, 16'h0000);
         chk(rd, {30'h0, tb[i][12], 1'b0});
      end
      // matches and wrapped sequences both left their sticky status bits
      apb(1'b0, `ASC_OFS_STAT, 16'h0000);
      chk(rd, 32'h3);
      apb(1'b1, `ASC_OFS_STAT, 16'h0003);
      chk({31'h0, irq}, 32'h0);
      $display("test compare modes done");
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_mux();
      t_regs();
      t_scan();
      t_modes();
      end_of_test();
   end
endmodule
bind asc_top asc_top_chk #(.PIN_COUNT(PIN_COUNT)) chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .conv_done(conv_done), .neg_select(neg_select), .neg_ground(neg_ground),
   .neg_input(neg_input), .sampling(sampling), .conv_start(conv_start),
   .conv_chan(conv_chan), .current_source_en(current_source_en));
